//--- core/uam_pkg.sv
// package for the multiprocessor serial port control and address match block.
// assumes an apb master on pclk and a bit-level receiver/transmitter on pclk.
package uam_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indexes; the byte address is four times the index
    localparam logic [7:0] UAM_IDX_POWER_CONTROL = 8'h87;
    localparam logic [7:0] UAM_IDX_SERIAL_CONTROL = 8'h98;
    localparam logic [7:0] UAM_IDX_SLAVE_ADDRESS = 8'hA9;
    localparam logic [7:0] UAM_IDX_SLAVE_ADDRESS_MASK = 8'hB9;
    localparam logic [11:0] UAM_ADDR_POWER_CONTROL = {2'h0, UAM_IDX_POWER_CONTROL, 2'h0};
    localparam logic [11:0] UAM_ADDR_SERIAL_CONTROL = {2'h0, UAM_IDX_SERIAL_CONTROL, 2'h0};
    localparam logic [11:0] UAM_ADDR_SLAVE_ADDRESS = {2'h0, UAM_IDX_SLAVE_ADDRESS, 2'h0};
    localparam logic [11:0] UAM_ADDR_SLAVE_ADDRESS_MASK =
        {2'h0, UAM_IDX_SLAVE_ADDRESS_MASK, 2'h0};

    ////////////////////////////////////////////////////////////////////////////
    // serial control bit positions
    localparam int UAM_SC_MODE_HI = 7;      // also the framing error view
    localparam int UAM_SC_MODE_LO = 6;
    localparam int UAM_SC_MULTIPROC = 5;
    localparam int UAM_SC_RX_ENABLE = 4;
    localparam int UAM_SC_TX_NINTH = 3;
    localparam int UAM_SC_RX_NINTH = 2;
    localparam int UAM_SC_TX_DONE = 1;
    localparam int UAM_SC_RX_DONE = 0;
    // power control bit positions
    localparam int UAM_PC_BAUD_DOUBLER = 7;
    localparam int UAM_PC_ERROR_FLAG_SELECT = 6;

    // values after reset
    localparam logic [7:0] UAM_RST_SERIAL_CONTROL = 8'h00;
    localparam logic [7:0] UAM_RST_SLAVE_ADDRESS = 8'h00;
    localparam logic [7:0] UAM_RST_SLAVE_ADDRESS_MASK = 8'h00;

    // fixed clock divisors; zero means the rate comes from the baud timer
    localparam logic [6:0] UAM_DIV_SHIFT = 7'h0C;
    localparam logic [6:0] UAM_DIV_SHIFT_DBL = 7'h06;
    localparam logic [6:0] UAM_DIV_NINE = 7'h40;
    localparam logic [6:0] UAM_DIV_NINE_FAST = 7'h20;
    localparam logic [6:0] UAM_DIV_VARIABLE = 7'h00;

    // serial modes as the two mode select bits encode them
    typedef enum logic [1:0]
    {
        UAM_MODE_SHIFT = 2'b00,
        UAM_MODE_UART8 = 2'b01,
        UAM_MODE_UART9_FIXED = 2'b10,
        UAM_MODE_UART9_VAR = 2'b11
    } uam_mode_t;

    // events from the bit-level receiver
    typedef struct packed
    {
        logic data_end;     // end of the last data bit (8th bit in mode 0)
        logic stop_end;     // stop bit sampled
        logic [7:0] data;   // received byte, valid with data_end
        logic ninth;        // received ninth bit, valid with data_end
        logic stop_ok;      // stop bit was high, valid with stop_end
    } uam_rx_evt_t;

    // events from the bit-level transmitter
    typedef struct packed
    {
        logic bit8_end;     // end of the 8th bit time, mode 0
        logic stop_start;   // start of the stop bit, other modes
    } uam_tx_evt_t;

    // apb request as one bundle
    typedef struct packed
    {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } uam_apb_req_t;

endpackage : uam_pkg

//--- core/uam_core.sv
// serial port control, status and automatic address recognition, apb slave.
// assumes the bit-level receiver and transmitter run on pclk and give
// one-cycle event pulses; the data buffer and baud timer live outside.

// Operation
// R1: address recognition only while multiproc_enable set
// R2: address frames raise rx flag only on match
// R3: mode 1: stop bit replaces ninth bit
// R4: mode 0 ignores multiproc_enable
// R5: given address: mask zeros are don't-care
// R6: broadcast address: address OR mask, zeros don't-care
// R7: accept on given or broadcast match
// R8: two mode bits select mode and rate
// R9: bit 7 framing error when select set
// R10: bit 7 upper mode bit when select clear
// R11: receive only while rx_enable set
// R12: modes 2/3 send tx_ninth_bit as ninth
// R13: modes 2/3 load received ninth bit
// R14: tx flag set at 8th bit/stop start
// R15: rx flag set end 8th bit mode 0
// R16: multiproc_enable active in modes 2 and 3
// R17: reset clears control, address and mask
// R18: framing check moves rx flag to stop
// R19: baud_doubler doubles rate in modes 1-3
// R20: ninth bit one marks address frame
// R21: master sends matching address then data frames
module uam_core
    import uam_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire uam_apb_req_t apb_req,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire uam_rx_evt_t rx_evt,
    input wire uam_tx_evt_t tx_evt,
    input wire logic double_speed_clock,
    output logic [1:0] serial_mode,
    output logic rx_enable,
    output logic tx_ninth_bit,
    output logic baud_double,
    output logic [6:0] fixed_divisor,
    output logic rx_accept,
    output logic rx_done_flag,
    output logic tx_done_flag,
    output logic framing_error_flag
);

    ////////////////////////////////////////////////////////////////////////////
    // all state of the block in one packed struct
    typedef struct packed
    {
        logic mode_select_hi;       // upper mode bit
        logic mode_select_lo;       // lower mode bit
        logic multiproc_enable;     // multiprocessor communication enable
        logic rx_enable;            // reception enable
        logic tx_ninth_bit;         // ninth bit to send
        logic rx_ninth_bit;         // ninth bit received
        logic tx_done_flag;         // transmit completion flag
        logic rx_done_flag;         // receive completion flag
        logic framing_error_flag;   // kept apart from the upper mode bit
        logic baud_doubler;         // rate doubling in modes 1-3
        logic error_flag_select;    // bit 7 shows the framing error
        logic [7:0] slave_address;  // individual address
        logic [7:0] slave_address_mask; // don't-care mask
        logic rx_pend;              // byte seen, flag decision waits for stop
        logic rx_pend_addr;         // pending frame was an address match
        logic [6:0] fixed_divisor;  // divisor shown to the baud logic
        logic rx_accept;            // one-cycle pulse: buffer may load
        logic pready;               // apb ready, high in the access phase
        logic [31:0] prdata;        // apb read data
        logic pslverr;              // apb error on unmapped address
    } uam_state_t;

    uam_state_t st;         // registered state
    uam_state_t next_st;    // next value of the state

    ////////////////////////////////////////////////////////////////////////////
    // decoded views of the current state
    uam_mode_t mode;        // serial mode from the two select bits
    logic mp_active;        // multiprocessor feature in force
    logic [7:0] given_care; // bits that must match the individual address
    logic [7:0] bcast_addr; // broadcast address
    logic given_hit;        // received byte matches the given address
    logic bcast_hit;        // received byte matches the broadcast address
    logic addr_hit;         // either match
    logic [7:0] sc_view;    // serial control as software reads it
    logic [7:0] pc_view;    // power control as software reads it

    // with the select bit set the upper mode bit is frozen as stored;
    // software then sees and writes the framing error in its place
    assign mode = uam_mode_t'({st.mode_select_hi, st.mode_select_lo}); // R8 R10

    // the feature never acts in the shift register mode
    assign mp_active = st.multiproc_enable && (mode != UAM_MODE_SHIFT); // R1 R4 R16

    // given address: only bits with a one in the mask take part
    assign given_care = st.slave_address_mask; // R5
    assign given_hit = ((rx_evt.data ^ st.slave_address) & given_care) == 8'h00; // R5

    // broadcast address: zeros of the OR are don't-care, ones must match
    assign bcast_addr = st.slave_address | st.slave_address_mask; // R6
    assign bcast_hit = ((rx_evt.data ^ bcast_addr) & bcast_addr) == 8'h00; // R6

    // a node answers to its given or its broadcast address
    assign addr_hit = given_hit || bcast_hit; // R7

    // read views; bit 7 is either the framing error or the upper mode bit
    always_comb
    begin
        sc_view = {st.error_flag_select ? st.framing_error_flag : st.mode_select_hi, // R9 R10
                   st.mode_select_lo, st.multiproc_enable, st.rx_enable,
                   st.tx_ninth_bit, st.rx_ninth_bit, st.tx_done_flag,
                   st.rx_done_flag};
        pc_view = 8'h00;
        pc_view[UAM_PC_BAUD_DOUBLER] = st.baud_doubler;
        pc_view[UAM_PC_ERROR_FLAG_SELECT] = st.error_flag_select;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state: bus writes first, hardware events after, so a set that
    // meets a software clear in the same cycle wins
    always_comb
    begin
        logic wr_en;        // write takes effect this edge
        logic setup;        // apb setup cycle
        logic decide_now;   // rx flag decision this cycle
        logic frame_ok;     // frame qualifies to raise the rx flag
        logic [7:0] wdat;   // low byte of the write data
        wr_en = 1'b0;
        setup = 1'b0;
        decide_now = 1'b0;
        frame_ok = 1'b0;
        wdat = apb_req.pwdata[7:0];
        next_st = st;
        next_st.rx_accept = 1'b0;

        // apb: zero-wait slave, ready in the first access cycle
        setup = apb_req.psel && !apb_req.penable;
        wr_en = apb_req.psel && apb_req.penable && st.pready && apb_req.pwrite;
        next_st.pready = setup;
        if (setup)
        begin
            // read data and error prepared in the setup cycle
            next_st.pslverr = 1'b0;
            unique case (apb_req.paddr)
                UAM_ADDR_SERIAL_CONTROL: next_st.prdata = {24'h000000, sc_view};
                UAM_ADDR_SLAVE_ADDRESS: next_st.prdata = {24'h000000, st.slave_address};
                UAM_ADDR_SLAVE_ADDRESS_MASK:
                    next_st.prdata = {24'h000000, st.slave_address_mask};
                UAM_ADDR_POWER_CONTROL: next_st.prdata = {24'h000000, pc_view};
                default:
                begin
                    // unmapped: reads zero, flagged as an error
                    next_st.prdata = 32'h00000000;
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
        else if (!(apb_req.psel && apb_req.penable))
        begin
            // idle: drop the error so it never leaks into a later cycle
            next_st.pslverr = 1'b0;
        end

        // register writes; unmapped writes change nothing
        if (wr_en)
        begin
            unique case (apb_req.paddr)
                UAM_ADDR_SERIAL_CONTROL:
                begin
                    if (st.error_flag_select)
                    begin
                        next_st.framing_error_flag = wdat[UAM_SC_MODE_HI]; // R9
                    end
                    else
                    begin
                        next_st.mode_select_hi = wdat[UAM_SC_MODE_HI]; // R10
                    end
                    next_st.mode_select_lo = wdat[UAM_SC_MODE_LO]; // R8
                    next_st.multiproc_enable = wdat[UAM_SC_MULTIPROC]; // R16
                    next_st.rx_enable = wdat[UAM_SC_RX_ENABLE]; // R11
                    next_st.tx_ninth_bit = wdat[UAM_SC_TX_NINTH]; // R12
                    next_st.rx_ninth_bit = wdat[UAM_SC_RX_NINTH];
                    next_st.tx_done_flag = wdat[UAM_SC_TX_DONE]; // R14
                    next_st.rx_done_flag = wdat[UAM_SC_RX_DONE]; // R15
                end
                UAM_ADDR_SLAVE_ADDRESS: next_st.slave_address = wdat;
                UAM_ADDR_SLAVE_ADDRESS_MASK: next_st.slave_address_mask = wdat;
                UAM_ADDR_POWER_CONTROL:
                begin
                    next_st.baud_doubler = wdat[UAM_PC_BAUD_DOUBLER]; // R19
                    next_st.error_flag_select = wdat[UAM_PC_ERROR_FLAG_SELECT]; // R18
                end
                default:
                begin
                end
            endcase
        end

        // transmit completion: mode decides which event marks the end
        if ((mode == UAM_MODE_SHIFT) ? tx_evt.bit8_end : tx_evt.stop_start)
        begin
            next_st.tx_done_flag = 1'b1; // R14
        end

        // receive path works only while reception is enabled
        if (st.rx_enable) // R11
        begin
            if (rx_evt.data_end)
            begin
                // ninth bit follows the line in the nine-bit modes
                if (mode == UAM_MODE_UART9_FIXED || mode == UAM_MODE_UART9_VAR)
                begin
                    next_st.rx_ninth_bit = rx_evt.ninth; // R13
                end
                if (mode == UAM_MODE_SHIFT)
                begin
                    // shift mode: flag at the end of the 8th bit, no filtering
                    decide_now = 1'b1; // R4 R15
                    frame_ok = 1'b1;
                end
                else if (st.error_flag_select || (mode == UAM_MODE_UART8 && mp_active))
                begin
                    // the decision waits for the stop bit
                    next_st.rx_pend = 1'b1; // R18 R3
                    next_st.rx_pend_addr = addr_hit;
                end
                else if (mp_active)
                begin
                    // only address frames that match reach software
                    decide_now = 1'b1;
                    frame_ok = rx_evt.ninth && addr_hit; // R2 R20 R7
                end
                else
                begin
                    decide_now = 1'b1;
                    frame_ok = 1'b1; // R1
                end
            end
            if (rx_evt.stop_end && st.rx_pend)
            begin
                next_st.rx_pend = 1'b0;
                decide_now = 1'b1;
                if (mode == UAM_MODE_UART8 && mp_active)
                begin
                    // stop bit stands in for the ninth bit
                    frame_ok = rx_evt.stop_ok && st.rx_pend_addr; // R3
                end
                else if (mp_active)
                begin
                    frame_ok = st.rx_ninth_bit && st.rx_pend_addr; // R2 R20
                end
                else
                begin
                    frame_ok = 1'b1; // R18
                end
            end
            // framing error: set on a bad stop, never cleared by a good one
            if (rx_evt.stop_end && !rx_evt.stop_ok && st.error_flag_select
                && mode != UAM_MODE_SHIFT)
            begin
                next_st.framing_error_flag = 1'b1; // R9
            end
        end
        else
        begin
            // a pending decision is dropped when reception is turned off
            next_st.rx_pend = 1'b0;
        end

        if (decide_now && frame_ok)
        begin
            next_st.rx_done_flag = 1'b1; // R15 R2
            next_st.rx_accept = 1'b1;
        end

        // divisor for the baud logic; zero hands the rate to the timer
        unique case (mode)
            UAM_MODE_SHIFT:
                next_st.fixed_divisor =
                    double_speed_clock ? UAM_DIV_SHIFT_DBL : UAM_DIV_SHIFT; // R8
            UAM_MODE_UART9_FIXED:
                next_st.fixed_divisor =
                    st.baud_doubler ? UAM_DIV_NINE_FAST : UAM_DIV_NINE; // R8 R19
            UAM_MODE_UART8, UAM_MODE_UART9_VAR:
                next_st.fixed_divisor = UAM_DIV_VARIABLE; // R8
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; reset brings every register to zero except fixed_divisor, which loads UAM_DIV_SHIFT
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0; // R17
            {st.mode_select_hi, st.mode_select_lo, st.multiproc_enable, st.rx_enable,
             st.tx_ninth_bit, st.rx_ninth_bit, st.tx_done_flag, st.rx_done_flag}
                <= UAM_RST_SERIAL_CONTROL; // R17
            st.slave_address <= UAM_RST_SLAVE_ADDRESS; // R17
            st.slave_address_mask <= UAM_RST_SLAVE_ADDRESS_MASK; // R17
            st.fixed_divisor <= UAM_DIV_SHIFT;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state flip-flops
    assign pready = st.pready;
    assign prdata = st.prdata;
    assign pslverr = st.pslverr;
    assign serial_mode = {st.mode_select_hi, st.mode_select_lo};
    assign rx_enable = st.rx_enable;
    assign tx_ninth_bit = st.tx_ninth_bit; // R12
    assign baud_double = st.baud_doubler; // R19
    assign fixed_divisor = st.fixed_divisor;
    assign rx_accept = st.rx_accept;
    assign rx_done_flag = st.rx_done_flag;
    assign tx_done_flag = st.tx_done_flag;
    assign framing_error_flag = st.framing_error_flag;

endmodule : uam_core

//--- sim/uam_chk.sv
// checker for the serial control and address match block.
// assumes it is bound to uam_core and sees only that module's ports.
module uam_chk
    import uam_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire uam_apb_req_t apb_req,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire uam_rx_evt_t rx_evt,
    input wire uam_tx_evt_t tx_evt,
    input wire logic double_speed_clock,
    input wire logic [1:0] serial_mode,
    input wire logic rx_enable,
    input wire logic tx_ninth_bit,
    input wire logic baud_double,
    input wire logic [6:0] fixed_divisor,
    input wire logic rx_accept,
    input wire logic rx_done_flag,
    input wire logic tx_done_flag,
    input wire logic framing_error_flag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////
    // expected divisor; the doubler has no say in mode 0
    function automatic logic [6:0] div_of(input logic [1:0] m, input logic ds, input logic dbl);
        return (m == 2'b00) ? (ds ? UAM_DIV_SHIFT_DBL : UAM_DIV_SHIFT) :
            (m == 2'b10) ? (dbl ? UAM_DIV_NINE_FAST : UAM_DIV_NINE) : UAM_DIV_VARIABLE;
    endfunction : div_of
    logic mapped; // address hits one of the four registers
    logic sc_wr; // software write to serial control, the only way to clear flags
    assign mapped = apb_req.paddr inside {UAM_ADDR_SERIAL_CONTROL, UAM_ADDR_SLAVE_ADDRESS,
        UAM_ADDR_SLAVE_ADDRESS_MASK, UAM_ADDR_POWER_CONTROL};
    assign sc_wr = apb_req.psel && apb_req.penable && apb_req.pwrite
        && apb_req.paddr == UAM_ADDR_SERIAL_CONTROL;
    ////////////////////////////////////////////////////////////////////////////
    property p_ready; apb_req.psel && !apb_req.penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access cycle");
    property p_err; pready && !mapped |-> pslverr && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_reset; $rose(presetn) |-> serial_mode == 2'b00 && !rx_enable && !rx_done_flag
        && !tx_done_flag; endproperty
    a_reset: assert property (p_reset) else $error("control not clear after reset");
    property p_rx_mode0; serial_mode == 2'b00 && rx_enable && rx_evt.data_end |=> rx_done_flag;
    endproperty
    a_rx_mode0: assert property (p_rx_mode0) else $error("shift mode frame lost");
    property p_rx_gate; rx_accept |-> $past(rx_enable)
        && ($past(rx_evt.data_end) || $past(rx_evt.stop_end)); endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("frame taken while disabled");
    property p_tx_done; (serial_mode == 2'b00 ? tx_evt.bit8_end : tx_evt.stop_start)
        |=> tx_done_flag; endproperty
    a_tx_done: assert property (p_tx_done) else $error("tx flag not set");
    property p_ferr_sticky; framing_error_flag && !sc_wr |=> framing_error_flag; endproperty
    a_ferr_sticky: assert property (p_ferr_sticky) else $error("framing flag lost");
    property p_div; presetn |=> fixed_divisor == div_of($past(serial_mode),
        $past(double_speed_clock), $past(baud_double)); endproperty
    a_div: assert property (p_div) else $error("divisor wrong for mode");
    // main scenarios seen at least once
    c_accept: cover property (rx_accept);
    c_ferr: cover property ($rose(framing_error_flag));
    c_err: cover property (pready && pslverr);
endmodule : uam_chk
bind uam_core uam_chk i_chk (.pclk, .presetn, .apb_req, .pready, .prdata, .pslverr, .rx_evt,
    .tx_evt, .double_speed_clock, .serial_mode, .rx_enable, .tx_ninth_bit, .baud_double,
    .fixed_divisor, .rx_accept, .rx_done_flag, .tx_done_flag, .framing_error_flag);

//--- sim/uam_peer.sv
// far-side model: the bit-level receiver and transmitter as seen by the core.
// assumes the bench calls its tasks; events change just after a rising edge.
module uam_peer
    import uam_pkg::*;
(
    input wire logic pclk,
    output uam_rx_evt_t rx_evt,
    output uam_tx_evt_t tx_evt
);
    timeunit 1ns;
    timeprecision 1ns;
    // quiet lines at start
    initial
    begin
        rx_evt = '0;
        tx_evt = '0;
    end
    // byte and ninth bit for one cycle, then inverted so stale data never match
    task automatic rx_data(input logic [7:0] d, input logic n);
        @(posedge pclk);
        rx_evt.data_end <= 1'b1;
        rx_evt.data <= d;
        rx_evt.ninth <= n;
        @(posedge pclk);
        rx_evt.data_end <= 1'b0;
        rx_evt.data <= ~d;
        rx_evt.ninth <= ~n;
    endtask : rx_data
    // stop bit sample with its quality
    task automatic rx_stop(input logic ok);
        @(posedge pclk);
        rx_evt.stop_end <= 1'b1;
        rx_evt.stop_ok <= ok;
        @(posedge pclk);
        rx_evt.stop_end <= 1'b0;
        rx_evt.stop_ok <= ~ok;
    endtask : rx_stop
    // one transmit event: eighth bit end or stop start
    task automatic tx_pulse(input logic m0);
        @(posedge pclk);
        tx_evt <= '{bit8_end: m0, stop_start: !m0};
        @(posedge pclk);
        tx_evt <= '0;
    endtask : tx_pulse
endmodule : uam_peer

//--- sim/uam_core_tb.sv
// bench for the serial control and address match block.
// assumes the core, the far-side model and the bound checker.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module uam_core_tb
    import uam_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] a_sc = UAM_ADDR_SERIAL_CONTROL;
    localparam logic [11:0] a_pc = UAM_ADDR_POWER_CONTROL;
    logic pclk, presetn, double_speed_clock, pready, pslverr, rx_accept, err;
    logic rx_done_flag, tx_done_flag, framing_error_flag, rx_enable, tx_ninth_bit, baud_double;
    logic [31:0] prdata, rd; // rd: last read data
    logic [1:0] serial_mode;
    logic [6:0] fixed_divisor, dv;
    logic [8:0] tv [6] = '{9'h157, 9'h15A, 9'h1FE, 9'h1FD, 9'h054, 9'h1FF}; // ninth, byte
    logic [7:0] sc;
    uam_apb_req_t apb_req;
    uam_rx_evt_t rx_evt;
    uam_tx_evt_t tx_evt;
    int n_fail, samples_checked, cycles;
    uam_core i_dut (.pclk, .presetn, .apb_req, .pready, .prdata, .pslverr, .rx_evt, .tx_evt,
        .double_speed_clock, .serial_mode, .rx_enable, .tx_ninth_bit, .baud_double,
        .fixed_divisor, .rx_accept, .rx_done_flag, .tx_done_flag, .framing_error_flag);
    uam_peer i_peer (.pclk, .rx_evt, .tx_evt);
    ////////////////////////////////////////////////////////////////////////////
    // one apb transfer; upper write bits set to show they are ignored
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'hFFFFFF, d}};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apb_req <= '0;
    endtask : apb
    // read and compare a whole word
    task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(rd, {24'h0, e})
    endtask : chk_rd
    // whole frame: data bits, a gap, then the stop bit
    task automatic frame(input logic [7:0] d, input logic n, input logic ok);
        i_peer.rx_data(d, n);
        repeat (3) @(posedge pclk);
        i_peer.rx_stop(ok);
    endtask : frame
    // verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard; a few hundred cycles are expected
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            print_verdict();
        end
    end
    // main sequence
    initial
    begin
        presetn = 1'b0;
        double_speed_clock = 1'b0;
        apb_req = '0;
        n_fail = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk_rd(a_sc, UAM_RST_SERIAL_CONTROL);
        chk_rd(UAM_ADDR_SLAVE_ADDRESS, UAM_RST_SLAVE_ADDRESS);
        chk_rd(UAM_ADDR_SLAVE_ADDRESS_MASK, UAM_RST_SLAVE_ADDRESS_MASK);
        apb(1'b1, 12'h264, 8'h5A);
        chk_rd(12'h264, 8'h00);
        `CHK(err, 1'b1)
        apb(1'b1, UAM_ADDR_SLAVE_ADDRESS, 8'h56);
        apb(1'b1, UAM_ADDR_SLAVE_ADDRESS_MASK, 8'hFC);
        chk_rd(UAM_ADDR_SLAVE_ADDRESS, 8'h56);
        chk_rd(UAM_ADDR_SLAVE_ADDRESS_MASK, 8'hFC);
        $display("test registers done");
        // shift mode ignores the multiprocessor bit
        apb(1'b1, a_sc, 8'h30);
        frame(8'h12, 1'b0, 1'b1);
        chk_rd(a_sc, 8'h31);
        // address table in mode 3: given 0101 01xx, broadcast 1111 111x
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, a_sc, 8'hF0 | {5'h0, ~tv[i][8], 2'b00});
            frame(tv[i][7:0], tv[i][8], 1'b1);
            sc = 8'hF0 | {5'h0, tv[i][8], 1'b0, tv[i][8] && ((((tv[i][7:0] ^ 8'h56) & 8'hFC)
                == 8'h00) || ((tv[i][7:0] & 8'hFE) == 8'hFE))};
            chk_rd(a_sc, sc);
        end
        apb(1'b1, a_sc, 8'hD0);
        frame(8'h00, 1'b0, 1'b1);
        chk_rd(a_sc, 8'hD1);
        apb(1'b1, a_sc, 8'hE0);
        frame(8'hFF, 1'b1, 1'b1);
        chk_rd(a_sc, 8'hE0);
        // mode 1 with recognition: the stop bit decides
        apb(1'b1, a_sc, 8'h70);
        frame(8'h57, 1'b0, 1'b0);
        chk_rd(a_sc, 8'h70);
        frame(8'h57, 1'b0, 1'b1);
        chk_rd(a_sc, 8'h71);
        $display("test receive done");
        // every mode with and without doubling; wrong event first, then right one
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, a_pc, {i[2], 7'h00});
            double_speed_clock <= i[2];
            apb(1'b1, a_sc, {i[1:0], 6'h08});
            repeat (2) @(posedge pclk);
            dv = (i[1:0] == 2'b00) ? (i[2] ? UAM_DIV_SHIFT_DBL : UAM_DIV_SHIFT) :
                (i[1:0] == 2'b10) ? (i[2] ? UAM_DIV_NINE_FAST : UAM_DIV_NINE) : UAM_DIV_VARIABLE;
            `CHK(fixed_divisor, dv)
            `CHK(serial_mode, i[1:0])
            `CHK(baud_double, i[2])
            `CHK(tx_ninth_bit, 1'b1)
            i_peer.tx_pulse(i[1:0] != 2'b00);
            chk_rd(a_sc, {i[1:0], 6'h08});
            i_peer.tx_pulse(i[1:0] == 2'b00);
            chk_rd(a_sc, {i[1:0], 6'h0A});
        end
        $display("test modes done");
        // framing check: flag waits for the stop bit, error sticks until written
        apb(1'b1, a_pc, 8'h40);
        chk_rd(a_pc, 8'h40);
        apb(1'b1, a_sc, 8'h50);
        i_peer.rx_data(8'h33, 1'b0);
        chk_rd(a_sc, 8'h50);
        i_peer.rx_stop(1'b0);
        frame(8'h33, 1'b0, 1'b1);
        apb(1'b0, a_sc, 8'h00);
        `CHK(rd[7], 1'b1)
        `CHK(rd[0], 1'b1)
        apb(1'b1, a_sc, 8'h50);
        @(posedge pclk);
        `CHK(framing_error_flag, 1'b0)
        $display("test framing done");
        print_verdict();
    end
endmodule : uam_core_tb
